/* File: core/psr_pin_sync.sv */
// Two flip-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/10ps
module psr_pin_sync #(
    parameter int WIDTH = 13
) (
    // Clock and reset.
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    // Pins and their synchronised copies.
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_pins_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_pins;
            sync_r <= meta_r;
        end
    end

    assign o_pins_sync = sync_r;

endmodule : psr_pin_sync

/* File: core/psr_top.sv */
// Eight-stage shift register with parallel or serial load and serial output.
`timescale 1ns/10ps
module psr_top
    import psr_pkg::*;
(
    // System clock and reset.
    input  wire logic                  i_mclk,
    input  wire logic                  i_sys_rst,
    // Clock pins of the register.
    input  wire logic                  i_shift_clk,
    input  wire logic                  i_clk_inhibit,
    // Clear pin, active low.
    input  wire logic                  i_clear_n,
    // Mode and data pins.
    input  wire logic                  i_shift_mode,
    input  wire logic                  i_serial_in,
    input  wire logic [PSR_STAGES-1:0] i_par_data,
    // Serial output.
    output logic                       o_last_stage_serial_out
);

    logic [PSR_PIN_W-1:0] pins_raw;
    logic [PSR_PIN_W-1:0] pins_s;
    logic                 clk_s;
    logic                 inh_s;
    logic                 clr_s;
    logic                 mode_s;
    logic                 ser_s;
    psr_stage_t           par_s;
    logic                 gate_nor;
    logic                 gate_nor_r;
    logic                 adv;
    psr_stage_t           stage_r;
    psr_stage_t           stage_nxt;
    psr_stage_t           stage_shifted;

    assign pins_raw = {i_par_data, i_serial_in, i_shift_mode, i_clear_n,
                       i_clk_inhibit, i_shift_clk};

    // Every pin passes two flip-flops before any logic reads it.
    psr_pin_sync #(
        .WIDTH       (PSR_PIN_W)
    ) u_pin_sync (
        .i_mclk      (i_mclk),
        .i_sys_rst   (i_sys_rst),
        .i_pins      (pins_raw),
        .o_pins_sync (pins_s)
    );

    assign clk_s  = pins_s[PSR_POS_CLK];
    assign inh_s  = pins_s[PSR_POS_INH];
    assign clr_s  = ~pins_s[PSR_POS_CLR_N];
    assign mode_s = pins_s[PSR_POS_MODE];
    assign ser_s  = pins_s[PSR_POS_SER];
    assign par_s  = pins_s[PSR_POS_PAR +: PSR_STAGES];

    assign gate_nor = ~(clk_s | inh_s);

    // Previous gate level, reset to the stopped level so release makes no edge.
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            gate_nor_r <= 1'b1;
        end else begin
            gate_nor_r <= gate_nor;
        end
    end

    // inhibit raised while clock high.
    // The register advances when the gated clock input rises, that is when the NOR output
    // falls; raising inhibit while the clock is high therefore makes no edge.
    assign adv = gate_nor_r & ~gate_nor;

    assign stage_shifted = {stage_r[PSR_STAGES-2:0], ser_s};

    generate
        for (genvar i = 0; i < PSR_STAGES; i++) begin : g_stage
            always_comb begin
                if (clr_s) begin
                    stage_nxt[i] = PSR_STAGE_RST[i];
                end else if (!adv) begin
                    stage_nxt[i] = stage_r[i];
                end else if (mode_s == PSR_MODE_SHIFT) begin
                    stage_nxt[i] = stage_shifted[i];
                end else begin
                    stage_nxt[i] = par_s[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            stage_r <= PSR_STAGE_RST;
        end else begin
            stage_r <= stage_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_last_stage_serial_out <= PSR_STAGE_RST[PSR_STAGES-1];
        end else begin
            o_last_stage_serial_out <= stage_nxt[PSR_STAGES-1];
        end
    end

endmodule : psr_top

/* File: dv/psr_pin_drv.sv */
// Behavioural model of the logic that drives the register pins.
`timescale 1ns/10ps
module psr_pin_drv (
    input  wire logic  i_mclk,
    output logic       o_clk, o_inh, o_clr_n, o_mode, o_ser, o_done,
    output logic [7:0] o_par
);
    initial {o_clk, o_inh, o_clr_n, o_mode, o_ser, o_done, o_par} = 14'h0800;
    task automatic wc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : wc
    task automatic pulse(input logic m, s, input logic [7:0] d, input int sel);
        {o_mode, o_ser, o_par} = {m, s, d};
        wc(1 + $urandom % 3);
        if (sel == 1) o_inh = 1'b1;
        else o_clk = 1'b1;
        wc(3);
        if (sel == 2) begin
            o_inh = 1'b1;
            wc(3);
            o_clk = 1'b0;
            wc(3);
            o_clk = 1'b1;
            wc(3);
        end
        {o_clk, o_inh} = 2'h0;
        wc(3);
        o_done = 1'b1;
        wc(1);
        o_done = 1'b0;
    endtask : pulse
    task automatic clr();
        o_clr_n = 1'b0;
        wc(3);
        o_clk = 1'b1;
        wc(3);
        o_done = 1'b1;
        wc(1);
        {o_done, o_clk} = 2'h0;
        wc(3);
        o_clr_n = 1'b1;
        wc(3);
    endtask : clr
endmodule : psr_pin_drv

/* File: dv/psr_top_props.sv */
// Assertions on the shift register pins and serial output.
`timescale 1ns/10ps
module psr_top_props (
    input wire logic       i_mclk, i_sys_rst, i_shift_clk, i_clk_inhibit, i_clear_n,
    input wire logic       i_shift_mode, o_last_stage_serial_out,
    input wire logic [7:0] i_par_data
);
    wire c = i_shift_clk, h = i_clk_inhibit, n = i_clear_n, q = o_last_stage_serial_out;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    rst_zero_a: assert property ($fell(i_sys_rst) |-> !q)
        else $error("no reset");
    clr_hold_a: assert property (!n [*4] |-> !q)
        else $error("clear lost");
    clr_time_a: assert property ($fell(n) |-> ##3 !q)
        else $error("clear late");
    ld_clk_a: assert property ($rose(c) && !h && !i_shift_mode && n
        |-> ##3 q == $past(i_par_data[7], 3)) else $error("load bad");
    ld_inh_a: assert property ($rose(h) && !c && !i_shift_mode && n
        |-> ##3 q == $past(i_par_data[7], 3)) else $error("gate clock bad");
    blocked_a: assert property ($rose(c) && h |-> ##3 $stable(q))
        else $error("clocked while inhibited");
    chg_src_a: assert property (!$stable(q)
        |-> !$past(n, 3) || $past(c | h, 3) && !$past(c | h, 4)) else $error("stray change");
    stand_a: assert property ($rose(c) && !h |-> ##4 $stable(q) [*3])
        else $error("output moved");
endmodule : psr_top_props
bind psr_top psr_top_props i_psr_top_props (.*);

/* File: dv/tb_psr_top.sv */
// Self-checking bench for the eight-stage shift register.
`timescale 1ns/10ps
module tb_psr_top;
    logic       i_mclk = 1'b0, i_sys_rst = 1'b1, clk, inh, clr_n, mode, ser, done, o;
    logic [7:0] par, e = 8'h00;
    logic       q[$];
    int         n_fail = 0, checks_done = 0;
    initial forever #12.5 i_mclk = ~i_mclk;
    psr_pin_drv i_psr_pin_drv (.i_mclk, .o_clk(clk), .o_inh(inh), .o_clr_n(clr_n),
        .o_mode(mode), .o_ser(ser), .o_done(done), .o_par(par));
    psr_top i_psr_top (.i_mclk, .i_sys_rst, .i_shift_clk(clk), .i_clk_inhibit(inh),
        .i_clear_n(clr_n), .i_shift_mode(mode), .i_serial_in(ser), .i_par_data(par),
        .o_last_stage_serial_out(o));
    task automatic chk(input logic seen, want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD %0t serial output mismatch", $time);
        end
    endtask : chk
    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic op(input logic m);
        logic       s;
        logic [7:0] d;
        s = 1'($urandom);
        d = 8'($urandom);
        e = m ? {e[6:0], s} : d;
        q.push_back(e[7]);
        i_psr_pin_drv.pulse(m, s, d, $urandom % 3);
    endtask : op
    always @(posedge i_mclk) if (done && q.size() > 0) chk(o, q.pop_front());
    initial begin
        void'($urandom(31));
        repeat (8) @(posedge i_mclk);
        #1 i_sys_rst = 1'b0;
        repeat (3) @(posedge i_mclk);
        #1;
        repeat (4) begin
            op(1'b0);
            repeat (9) op(1'b1);
        end
        // all-ones load gives the clear ones to remove.
        e = 8'hFF;
        q.push_back(1'b1);
        i_psr_pin_drv.pulse(1'b0, 1'b0, 8'hFF, 0);
        e = 8'h00;
        q.push_back(1'b0);
        i_psr_pin_drv.clr();
        repeat (9) op(1'b1);
        complete_run();
    end
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
endmodule : tb_psr_top

/* File: shared/psr_pkg.sv */
// Constants shared by the eight-stage parallel or serial load shift register.
package psr_pkg;

    // Register geometry and reset value.
    localparam int          PSR_STAGES    = 8;
    localparam logic [7:0]  PSR_STAGE_RST = 8'h00;

    // Pin synchroniser depth and the layout of the synchronised pin vector.
    localparam int          PSR_SYNC_DEPTH = 2;
    localparam int          PSR_PIN_W      = 13;
    localparam int          PSR_POS_CLK    = 0;
    localparam int          PSR_POS_INH    = 1;
    localparam int          PSR_POS_CLR_N  = 2;
    localparam int          PSR_POS_MODE   = 3;
    localparam int          PSR_POS_SER    = 4;
    localparam int          PSR_POS_PAR    = 5;

    // Mode control level that selects serial shifting.
    localparam logic        PSR_MODE_SHIFT = 1'b1;

    typedef logic [PSR_STAGES-1:0] psr_stage_t;

endpackage : psr_pkg
